// *** rtl/irq_arbiter.sv ***
// Priority encoder choosing the highest pending interrupt level
`timescale 1ns/100ps
`default_nettype none
module irq_arbiter
(
  input  wire logic [31:0]               pending,
  input  wire logic                      small_cfg,
  output logic                           found,
  output logic [pmi_pkg::LVL_W-1:0]      level
);
  logic [31:0] masked;

  always_comb
  begin
    masked = small_cfg ? (pending & 32'h0000_00FF) : pending;
    found  = 1'b0;
    level  = '0;
    for (int i = 0; i < 32; i++)
    begin
      if (masked[i])
      begin
        found = 1'b1;
        level = pmi_pkg::LVL_W'(i);
      end
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// *** rtl/mode_guard.sv ***
// Instruction and memory permission check by operating mode
`timescale 1ns/100ps
`default_nettype none
module mode_guard
(
  input  wire logic [1:0] cur_mode,
  input  wire logic       instr_valid,
  input  wire logic       instr_priv,
  input  wire logic       mem_valid,
  input  wire logic       mem_write,
  input  wire logic       mem_own_space,
  input  wire logic [1:0] mem_owner_mode,
  input  wire logic [1:0] mem_prot,
  output logic            priv_fault,
  output logic            mem_fault
);
  logic write_bad;
  logic read_bad;

  always_comb
  begin
    // Only kernel runs privileged instructions; supervisor/user equal
    priv_fault = instr_valid && instr_priv &&
                 (cur_mode != 2'(pmi_pkg::MODE_KERNEL));
    // mem_prot[0] shields reads, mem_prot[1] shields writes
    write_bad  = mem_write && ((cur_mode > mem_owner_mode) && mem_prot[1]);
    read_bad   = !mem_write && ((cur_mode > mem_owner_mode) && mem_prot[0]);
    mem_fault  = mem_valid && (write_bad || read_bad ||
                 (mem_write && (cur_mode == 2'(pmi_pkg::MODE_USER)) && !mem_own_space));
  end
endmodule : mode_guard
`default_nettype wire

// *** rtl/pmi_pkg.sv ***
// Package with constants and types for the mode and interrupt-priority unit
package pmi_pkg;
  localparam int unsigned LVL_W          = 5;
  localparam int unsigned LVL_LARGE      = 32;
  localparam int unsigned LVL_SMALL      = 8;
  localparam int unsigned HW_LVL_LARGE   = 16;
  localparam int unsigned HW_LVL_SMALL   = 4;
  localparam int unsigned ADDR_W         = 32;
  localparam int unsigned CTX_W          = 32;
  localparam int unsigned CTX_WORDS      = 4;
  localparam int unsigned CTX_IDX_W      = 2;
  localparam int unsigned SLOT_W         = 6;
  localparam logic [ADDR_W-1:0] VEC_BASE = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] VEC_EXC  = 32'h0000_0100;
  localparam logic [LVL_W-1:0]  IPL_RST  = 5'h1F;
  localparam logic [CTX_IDX_W-1:0] CTX_LAST = 2'h3;

  typedef enum logic [1:0]
  {
    MODE_KERNEL     = 2'b00,
    MODE_EXECUTIVE  = 2'b01,
    MODE_SUPERVISOR = 2'b10,
    MODE_USER       = 2'b11
  } mode_t;

  typedef enum logic [2:0]
  {
    ST_RUN   = 3'b000,
    ST_VEC   = 3'b001,
    ST_SAVE  = 3'b010,
    ST_LOAD  = 3'b011,
    ST_DONE  = 3'b100
  } state_t;
endpackage : pmi_pkg

// *** rtl/priv_mode_irq_priority.sv ***
// Mode, interrupt priority, vector dispatch and context switch control
`timescale 1ns/100ps
`default_nettype none
module priv_mode_irq_priority
(
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           small_cfg,
  input  wire logic [15:0]                    hw_irq,
  input  wire logic [15:0]                    sw_irq,
  input  wire logic                           instr_boundary,
  input  wire logic                           exc_req,
  input  wire logic [pmi_pkg::SLOT_W-1:0]     exc_code,
  input  wire logic                           instr_valid,
  input  wire logic                           instr_priv,
  input  wire logic                           rei_req,
  input  wire logic [1:0]                     rei_mode,
  input  wire logic [pmi_pkg::LVL_W-1:0]      rei_level,
  input  wire logic                           rei_isr,
  input  wire logic                           mode_down_req,
  input  wire logic [1:0]                     mode_down,
  input  wire logic                           mem_valid,
  input  wire logic                           mem_write,
  input  wire logic                           mem_own_space,
  input  wire logic [1:0]                     mem_owner_mode,
  input  wire logic [1:0]                     mem_prot,
  input  wire logic                           ctx_req,
  input  wire logic [pmi_pkg::CTX_W-1:0]      ctx_live_word,
  output logic                                mem_rd,
  output logic [pmi_pkg::ADDR_W-1:0]          mem_rd_addr,
  input  wire logic                           mem_rd_ack,
  input  wire logic [pmi_pkg::ADDR_W-1:0]     mem_rd_data,
  output logic                                dispatch_valid,
  output logic [pmi_pkg::ADDR_W-1:0]          dispatch_addr,
  output logic                                ctx_save_valid,
  output logic [pmi_pkg::CTX_IDX_W-1:0]       ctx_index,
  output logic [pmi_pkg::CTX_W-1:0]           ctx_save_word,
  output logic                                ctx_load_valid,
  output logic [pmi_pkg::CTX_W-1:0]           ctx_load_word,
  output logic                                ctx_done,
  output logic                                busy,
  output logic [1:0]                          cur_mode,
  output logic [pmi_pkg::LVL_W-1:0]           cur_level,
  output logic                                isr_context,
  output logic                                priv_fault,
  output logic                                mem_fault
);
  pmi_pkg::state_t                  state_r, state_nxt;
  logic [1:0]                       mode_r, mode_nxt;
  logic [pmi_pkg::LVL_W-1:0]        ipl_r, ipl_nxt;
  logic                             isr_r, isr_nxt;
  logic [pmi_pkg::ADDR_W-1:0]       vaddr_r, vaddr_nxt;
  logic [pmi_pkg::LVL_W-1:0]        plvl_r, plvl_nxt;
  logic                             pirq_r, pirq_nxt;
  logic [pmi_pkg::CTX_IDX_W-1:0]    idx_r, idx_nxt;
  logic                             dv_r, dv_nxt;
  logic [pmi_pkg::ADDR_W-1:0]       da_r, da_nxt;
  logic                             sv_r, sv_nxt;
  logic [pmi_pkg::CTX_W-1:0]        sw_r, sw_nxt;
  logic                             lv_r, lv_nxt;
  logic [pmi_pkg::CTX_W-1:0]        lw_r, lw_nxt;
  logic                             cd_r, cd_nxt;
  logic [pmi_pkg::CTX_IDX_W-1:0]    oi_r, oi_nxt;
  logic                             bank_r, bank_nxt;
  logic [pmi_pkg::CTX_W-1:0]        ctx_mem [2*pmi_pkg::CTX_WORDS];
  logic [31:0]                      pending;
  logic                             irq_found;
  logic [pmi_pkg::LVL_W-1:0]        irq_level;
  logic                             take_irq;
  logic [1:0]                       rei_mode_ok;
  logic                             pf_raw;

  // Large: hardware on 31..16, software on 15..0; small: hardware 7..4, software 3..0
  always_comb
  begin
    if (small_cfg)
      pending = {24'h000000, hw_irq[3:0], sw_irq[3:0]};
    else
      pending = {hw_irq, sw_irq};
  end

  irq_arbiter u_arb
  (
    .pending   (pending),
    .small_cfg (small_cfg),
    .found     (irq_found),
    .level     (irq_level)
  );

  mode_guard u_guard
  (
    .cur_mode       (mode_r),
    .instr_valid    (instr_valid),
    .instr_priv     (instr_priv),
    .mem_valid      (mem_valid),
    .mem_write      (mem_write),
    .mem_own_space  (mem_own_space),
    .mem_owner_mode (mem_owner_mode),
    .mem_prot       (mem_prot),
    .priv_fault     (pf_raw),
    .mem_fault      (mem_fault)
  );

  assign priv_fault = pf_raw;

  // Interrupt accepted at a boundary when strictly above current level
  assign take_irq = (state_r == pmi_pkg::ST_RUN) && instr_boundary && irq_found &&
                    (irq_level > ipl_r);

  // Small configuration folds executive onto supervisor
  always_comb
  begin
    rei_mode_ok = rei_mode;
    if (small_cfg && (rei_mode == 2'(pmi_pkg::MODE_EXECUTIVE)))
      rei_mode_ok = 2'(pmi_pkg::MODE_SUPERVISOR);
  end

  always_comb
  begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    ipl_nxt   = ipl_r;
    isr_nxt   = isr_r;
    vaddr_nxt = vaddr_r;
    plvl_nxt  = plvl_r;
    pirq_nxt  = pirq_r;
    idx_nxt   = idx_r;
    dv_nxt    = 1'b0;
    da_nxt    = da_r;
    sv_nxt    = 1'b0;
    sw_nxt    = sw_r;
    lv_nxt    = 1'b0;
    lw_nxt    = lw_r;
    cd_nxt    = 1'b0;
    oi_nxt    = oi_r;
    bank_nxt  = bank_r;
    case (state_r)
      pmi_pkg::ST_RUN:
      begin
        if (exc_req || pf_raw)
        begin
          vaddr_nxt = pmi_pkg::VEC_EXC + {24'h000000, exc_code, 2'b00};
          pirq_nxt  = 1'b0;
          state_nxt = pmi_pkg::ST_VEC;
        end
        else if (take_irq)
        begin
          vaddr_nxt = pmi_pkg::VEC_BASE + {25'h0, irq_level, 2'b00};
          plvl_nxt  = irq_level;
          pirq_nxt  = 1'b1;
          state_nxt = pmi_pkg::ST_VEC;
        end
        else if (ctx_req)
        begin
          idx_nxt   = '0;
          state_nxt = pmi_pkg::ST_SAVE;
        end
        else if (rei_req)
        begin
          // Return may only drop privilege or stay level
          if (rei_mode_ok >= mode_r)
            mode_nxt = rei_mode_ok;
          if (rei_level < ipl_r)
            ipl_nxt = rei_level;
          // Staying in service context is only possible from inside it
          isr_nxt = rei_isr && isr_r;
          if (rei_isr && isr_r)
            mode_nxt = 2'(pmi_pkg::MODE_KERNEL);
        end
        else if (mode_down_req && !isr_r && (mode_down >= mode_r))
        begin
          if (small_cfg && (mode_down == 2'(pmi_pkg::MODE_EXECUTIVE)))
            mode_nxt = 2'(pmi_pkg::MODE_SUPERVISOR);
          else
            mode_nxt = mode_down;
        end
      end
      pmi_pkg::ST_VEC:
      begin
        if (mem_rd_ack)
        begin
          dv_nxt    = 1'b1;
          da_nxt    = mem_rd_data;
          mode_nxt  = 2'(pmi_pkg::MODE_KERNEL);
          if (pirq_r)
          begin
            ipl_nxt = plvl_r;
            isr_nxt = 1'b1;
          end
          state_nxt = pmi_pkg::ST_RUN;
        end
      end
      pmi_pkg::ST_SAVE:
      begin
        sv_nxt = 1'b1;
        sw_nxt = ctx_live_word;
        oi_nxt = idx_r;
        idx_nxt = idx_r + 2'h1;
        if (idx_r == pmi_pkg::CTX_LAST)
          state_nxt = pmi_pkg::ST_LOAD;
      end
      pmi_pkg::ST_LOAD:
      begin
        lv_nxt = 1'b1;
        lw_nxt = ctx_mem[{~bank_r, idx_r}];
        oi_nxt = idx_r;
        idx_nxt = idx_r + 2'h1;
        if (idx_r == pmi_pkg::CTX_LAST)
          state_nxt = pmi_pkg::ST_DONE;
      end
      pmi_pkg::ST_DONE:
      begin
        cd_nxt    = 1'b1;
        bank_nxt  = ~bank_r;
        state_nxt = pmi_pkg::ST_RUN;
      end
      default:
      begin
        state_nxt = pmi_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= pmi_pkg::ST_RUN;
      mode_r  <= 2'(pmi_pkg::MODE_KERNEL);
      ipl_r   <= pmi_pkg::IPL_RST;
      isr_r   <= 1'b0;
      vaddr_r <= '0;
      plvl_r  <= '0;
      pirq_r  <= 1'b0;
      idx_r   <= '0;
      dv_r    <= 1'b0;
      da_r    <= '0;
      sv_r    <= 1'b0;
      sw_r    <= '0;
      lv_r    <= 1'b0;
      lw_r    <= '0;
      cd_r    <= 1'b0;
      oi_r    <= '0;
      bank_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      ipl_r   <= ipl_nxt;
      isr_r   <= isr_nxt;
      vaddr_r <= vaddr_nxt;
      plvl_r  <= plvl_nxt;
      pirq_r  <= pirq_nxt;
      idx_r   <= idx_nxt;
      dv_r    <= dv_nxt;
      da_r    <= da_nxt;
      sv_r    <= sv_nxt;
      sw_r    <= sw_nxt;
      lv_r    <= lv_nxt;
      lw_r    <= lw_nxt;
      cd_r    <= cd_nxt;
      oi_r    <= oi_nxt;
      bank_r  <= bank_nxt;
    end
  end

  // Two banks: a switch saves into one and loads what the previous switch saved in the other
  always_ff @(posedge sys_clk)
  begin
    if (state_r == pmi_pkg::ST_SAVE)
      ctx_mem[{bank_r, idx_r}] <= ctx_live_word;
  end

  assign mem_rd         = (state_r == pmi_pkg::ST_VEC);
  assign mem_rd_addr    = vaddr_r;
  assign dispatch_valid = dv_r;
  assign dispatch_addr  = da_r;
  assign ctx_save_valid = sv_r;
  assign ctx_save_word  = sw_r;
  assign ctx_load_valid = lv_r;
  assign ctx_load_word  = lw_r;
  assign ctx_index      = oi_r;
  assign ctx_done       = cd_r;
  assign busy           = (state_r != pmi_pkg::ST_RUN);
  assign cur_mode       = mode_r;
  assign cur_level      = ipl_r;
  assign isr_context    = isr_r;
endmodule : priv_mode_irq_priority
`default_nettype wire

// *** tb/pmi_checker_assertions.sv ***
// Assertion checker for the mode and interrupt-priority unit
`timescale 1ns/100ps
`default_nettype none
module pmi_checker
(
  input wire logic                          sys_clk,
  input wire logic                          reset,
  input wire logic                          instr_valid,
  input wire logic                          instr_priv,
  input wire logic                          mem_valid,
  input wire logic                          mem_write,
  input wire logic                          mem_own_space,
  input wire logic [1:0]                    mem_owner_mode,
  input wire logic [1:0]                    mem_prot,
  input wire logic                          mem_rd,
  input wire logic [pmi_pkg::ADDR_W-1:0]    mem_rd_addr,
  input wire logic                          mem_rd_ack,
  input wire logic                          dispatch_valid,
  input wire logic                          ctx_save_valid,
  input wire logic [pmi_pkg::CTX_IDX_W-1:0] ctx_index,
  input wire logic                          ctx_load_valid,
  input wire logic                          ctx_done,
  input wire logic [1:0]                    cur_mode,
  input wire logic [pmi_pkg::LVL_W-1:0]     cur_level,
  input wire logic                          isr_context,
  input wire logic                          priv_fault,
  input wire logic                          mem_fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_vector_hold: assert property (mem_rd && !mem_rd_ack |=> mem_rd && $stable(mem_rd_addr))
    else $error("vector fetch dropped or moved before acknowledge");
  chk_dispatch_ack: assert property (mem_rd && mem_rd_ack |=> dispatch_valid)
    else $error("no dispatch after vector read");
  chk_dispatch_cause: assert property (dispatch_valid |-> $past(mem_rd) && $past(mem_rd_ack))
    else $error("dispatch without vector read");
  chk_isr_kernel: assert property (isr_context |-> cur_mode == 2'b00)
    else $error("service context outside kernel mode");
  chk_kernel_all: assert property (instr_valid && cur_mode == 2'b00 |-> !priv_fault)
    else $error("kernel instruction refused");
  chk_user_priv: assert property (instr_valid && instr_priv && cur_mode == 2'b11 |-> priv_fault)
    else $error("user privileged instruction allowed");
  chk_super_user: assert property (instr_valid && cur_mode == 2'b10 |-> priv_fault == instr_priv)
    else $error("supervisor privilege differs from user");
  chk_user_write: assert property (mem_valid && mem_write && cur_mode == 2'b11 && !mem_own_space |-> mem_fault)
    else $error("user write outside own space allowed");
  chk_read_shield: assert property (mem_valid && !mem_write && mem_prot[0] && cur_mode > mem_owner_mode |-> mem_fault)
    else $error("shielded read allowed");
  chk_ctx_order: assert property (ctx_save_valid && ctx_index == 2'h3 |=>
    ctx_load_valid && ctx_index == 2'h0 ##3 ctx_load_valid && ctx_index == 2'h3 ##1 ctx_done)
    else $error("context load order wrong");
  chk_mode_raise: assert property (cur_mode < $past(cur_mode) |-> dispatch_valid)
    else $error("privilege raised without dispatch");
  chk_level_raise: assert property (cur_level > $past(cur_level) |-> dispatch_valid && isr_context)
    else $error("level raised without interrupt");
endmodule : pmi_checker

bind priv_mode_irq_priority pmi_checker pmi_checker_inst (.sys_clk(sys_clk), .reset(reset),
  .instr_valid(instr_valid), .instr_priv(instr_priv), .mem_valid(mem_valid), .mem_write(mem_write),
  .mem_own_space(mem_own_space), .mem_owner_mode(mem_owner_mode), .mem_prot(mem_prot), .mem_rd(mem_rd),
  .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .dispatch_valid(dispatch_valid),
  .ctx_save_valid(ctx_save_valid), .ctx_index(ctx_index), .ctx_load_valid(ctx_load_valid),
  .ctx_done(ctx_done), .cur_mode(cur_mode), .cur_level(cur_level), .isr_context(isr_context),
  .priv_fault(priv_fault), .mem_fault(mem_fault));
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench for the mode and interrupt-priority unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk, reset, small_cfg, instr_boundary, exc_req, instr_valid, instr_priv, rei_req, rei_isr;
  logic mode_down_req, mem_valid, mem_write, mem_own_space, ctx_req, mem_rd, mem_rd_ack, dispatch_valid;
  logic ctx_save_valid, ctx_load_valid, ctx_done, busy, isr_context, priv_fault, mem_fault, have_prev;
  logic [15:0] hw_irq, sw_irq;
  logic [5:0]  exc_code;
  logic [4:0]  rei_level, cur_level, lvl;
  logic [1:0]  rei_mode, mode_down, mem_owner_mode, mem_prot, ctx_index, cur_mode, ack_delay;
  logic [31:0] ctx_seed, ctx_live_word, mem_rd_addr, mem_rd_data, dispatch_addr, ctx_save_word, ctx_load_word;
  logic [31:0] saved_now[4], saved_prev[4];
  logic [31:0] live_prev;
  logic [32:0] exp_q[$];
  int          miscompares, n_compared, n_done, seed_val;

  always @(posedge sys_clk)
  begin
    #5;
    ctx_live_word = ctx_seed ^ $urandom;
  end
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  priv_mode_irq_priority priv_mode_irq_priority_inst (.sys_clk(sys_clk), .reset(reset), .small_cfg(small_cfg),
    .hw_irq(hw_irq), .sw_irq(sw_irq), .instr_boundary(instr_boundary), .exc_req(exc_req), .exc_code(exc_code),
    .instr_valid(instr_valid), .instr_priv(instr_priv), .rei_req(rei_req), .rei_mode(rei_mode),
    .rei_level(rei_level), .rei_isr(rei_isr), .mode_down_req(mode_down_req), .mode_down(mode_down),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_own_space(mem_own_space),
    .mem_owner_mode(mem_owner_mode), .mem_prot(mem_prot), .ctx_req(ctx_req), .ctx_live_word(ctx_live_word),
    .mem_rd(mem_rd), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .dispatch_valid(dispatch_valid), .dispatch_addr(dispatch_addr), .ctx_save_valid(ctx_save_valid),
    .ctx_index(ctx_index), .ctx_save_word(ctx_save_word), .ctx_load_valid(ctx_load_valid),
    .ctx_load_word(ctx_load_word), .ctx_done(ctx_done), .busy(busy), .cur_mode(cur_mode),
    .cur_level(cur_level), .isr_context(isr_context), .priv_fault(priv_fault), .mem_fault(mem_fault));

  vector_mem_model vector_mem_model_inst (.sys_clk(sys_clk), .reset(reset), .mem_rd(mem_rd),
    .mem_rd_addr(mem_rd_addr), .delay(ack_delay), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic end_sim;
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic tick;
    @(posedge sys_clk);
    #5;
  endtask : tick

  task automatic wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0)
    begin
      tick;
      i++;
      if (i > 100)
      begin
        miscompares++;
        end_sim;
      end
    end
  endtask : wait_idle

  task automatic set_mode(input logic [1:0] m);
    mode_down = m;
    mode_down_req = 1'b1;
    tick;
    mode_down_req = 1'b0;
    tick;
  endtask : set_mode

  task automatic do_rei(input logic [1:0] m, input logic [4:0] l);
    rei_mode = m;
    rei_level = l;
    rei_req = 1'b1;
    tick;
    rei_req = 1'b0;
    tick;
  endtask : do_rei

  task automatic do_exc(input logic [5:0] code);
    exc_code = code;
    ack_delay = 2'($urandom);
    exp_q.push_back({1'b0, ~(32'h0000_0100 + {24'h0, code, 2'h0})});
    exc_req = 1'b1;
    tick;
    exc_req = 1'b0;
    wait_idle;
    check("cur_mode", 32'h0, cur_mode);
  endtask : do_exc

  task automatic priv_trap;
    exp_q.push_back({1'b0, ~(32'h0000_0100 + {24'h0, exc_code, 2'h0})});
    instr_valid = 1'b1;
    instr_priv = 1'b1;
    #1 check("priv_fault", 32'h1, priv_fault);
    tick;
    instr_valid = 1'b0;
    wait_idle;
    check("cur_mode", 32'h0, cur_mode);
  endtask : priv_trap

  always @(posedge sys_clk)
    if (!reset)
    begin
      if (dispatch_valid === 1'b1)
      begin
        if (exp_q.size() == 0)
          check("dispatch_count", 32'h0, 32'h1);
        else if (!exp_q[0][32])
          check("dispatch_addr", exp_q[0][31:0], dispatch_addr);
        if (exp_q.size() != 0)
          void'(exp_q.pop_front());
      end
      if (ctx_save_valid === 1'b1)
      begin
        check("ctx_save_word", live_prev, ctx_save_word);
        saved_now[ctx_index] = ctx_save_word;
      end
      if (ctx_load_valid === 1'b1 && have_prev)
        check("ctx_load_word", saved_prev[ctx_index], ctx_load_word);
      if (ctx_done === 1'b1)
      begin
        saved_prev = saved_now;
        have_prev = 1'b1;
        n_done++;
      end
      live_prev = ctx_live_word;
    end

  initial
  begin
    {small_cfg, instr_boundary, exc_req, instr_valid, instr_priv, rei_req, rei_isr, mode_down_req} = '0;
    {mem_valid, mem_write, mem_own_space, ctx_req, have_prev} = '0;
    {hw_irq, sw_irq, exc_code, rei_level, rei_mode, mode_down, mem_owner_mode, mem_prot, ack_delay} = '0;
    ctx_seed = 32'h0;
    reset = 1'b1;
    seed_val = $urandom(32'h59660792);
    repeat (10) @(posedge sys_clk);
    #5 reset = 1'b0;
    check("cur_mode", 32'h0, cur_mode);
    check("cur_level", 32'h1F, cur_level);
    hw_irq = 16'h8000;
    instr_boundary = 1'b1;
    repeat (3) tick;
    check("busy", 32'h0, busy);
    {hw_irq, instr_boundary, instr_valid, instr_priv} = 4'b0011;
    #1 check("priv_fault", 32'h0, priv_fault);
    {instr_valid, instr_priv} = 2'b00;
    set_mode(2'h1);
    check("cur_mode", 32'h1, cur_mode);
    do_exc(6'($urandom));
    small_cfg = 1'b1;
    set_mode(2'h1);
    check("cur_mode", 32'h2, cur_mode);
    small_cfg = 1'b0;
    do_exc(6'h3F);
    set_mode(2'h2);
    priv_trap;
    set_mode(2'h3);
    set_mode(2'h0);
    check("cur_mode", 32'h3, cur_mode);
    {mem_valid, mem_write, mem_own_space} = 3'b110;
    #1 check("mem_fault", 32'h1, mem_fault);
    {mem_write, mem_prot} = 3'b001;
    #1 check("mem_fault", 32'h1, mem_fault);
    mem_valid = 1'b0;
    priv_trap;
    do_rei(2'h3, 5'h0);
    for (int it = 0; it < 10; it++)
    begin
      small_cfg = it[0];
      hw_irq = (it % 3 == 0) ? 16'h0 : 16'($urandom);
      sw_irq = 16'($urandom) | 16'h0002;
      if (small_cfg)
      begin
        hw_irq = hw_irq & 16'h000F;
        sw_irq = sw_irq & 16'h000F;
      end
      for (int i = 0; i < 16; i++)
        if (sw_irq[i])
          lvl = 5'(i);
      for (int i = 0; i < 16; i++)
        if (hw_irq[i])
          lvl = 5'(i + (small_cfg ? 4 : 16));
      repeat (3) tick;
      check("isr_context", 32'h0, isr_context);
      exp_q.push_back({1'b0, ~{25'h0, lvl, 2'h0}});
      instr_boundary = 1'b1;
      tick;
      wait_idle;
      repeat (3) tick;
      check("cur_level", {27'h0, lvl}, cur_level);
      check("isr_context", 32'h1, isr_context);
      {hw_irq, sw_irq, instr_boundary} = '0;
      do_rei(2'h3, 5'h0);
    end
    for (int k = 0; k < 2; k++)
    begin
      ctx_seed = $urandom;
      ctx_req = 1'b1;
      tick;
      ctx_req = 1'b0;
      wait_idle;
      tick;
    end
    check("ctx_done_count", 32'h2, n_done);
    check("dispatch_left", 32'h0, exp_q.size());
    end_sim;
  end
endmodule : testbench
`default_nettype wire

// *** tb/vector_mem_model.sv ***
// Memory model answering vector fetches after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module vector_mem_model
(
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  input  wire logic                       mem_rd,
  input  wire logic [pmi_pkg::ADDR_W-1:0] mem_rd_addr,
  input  wire logic [1:0]                 delay,
  output logic                            mem_rd_ack,
  output logic [pmi_pkg::ADDR_W-1:0]      mem_rd_data
);
  logic [1:0] wait_r;

  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= 32'h5A5A_A5A5;
      wait_r      <= 2'h0;
    end
    else if (mem_rd && !mem_rd_ack && wait_r == delay)
    begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= ~mem_rd_addr; // Vector content tied to its location
      wait_r      <= 2'h0;
    end
    else
    begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= {mem_rd_data[30:0], ~mem_rd_data[31]};
      wait_r      <= (mem_rd && !mem_rd_ack) ? wait_r + 2'h1 : 2'h0;
    end
endmodule : vector_mem_model
`default_nettype wire
